// File: sirq_bank.sv
// sirq_bank: sticky event flags of the second interrupt group, with
// masks and one level interrupt output.
// assumes: event sources are asynchronous levels; registers are reached
// over a plain strobe port with read data one cycle after the strobe.
//
// Behaviour
// - sixteen core request flags at 0x190A
// - short flags per output at 0x190B
// - enable-done flags at 0x190C bits 5:0
// - disable-done flags at 0x190D, same layout
// - converter saturation sets bit 12 of 0x190E
// - flags stick until written one; zero ignored
//
// Strobed register access was chosen for this implementation.

`timescale 1ns/1ns

module sirq_bank #(
	parameter int ADDR_W = sirq_pkg::ADDR_W,
	parameter int DATA_W = sirq_pkg::DATA_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [15:0] core_req,
	input wire logic [7:0] out_short,
	input wire logic [5:0] out_on_done,
	input wire logic [5:0] out_off_done,
	input wire logic converter_clip,
	output logic irq
);

	// ************************************************************
	// event inputs
	// ************************************************************
	logic [sirq_pkg::EV_W-1:0] ev_raw; // all sources side by side
	logic [sirq_pkg::EV_W-1:0] ev_level; // synchronised levels
	logic [sirq_pkg::EV_W-1:0] ev_rise; // one-cycle rising pulses

	// gather the sources in a fixed order
	assign ev_raw = {converter_clip, out_off_done, out_on_done, out_short, core_req};

	// bring every source into the clk domain
	sirq_sync #(
		.W(sirq_pkg::EV_W)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.async_in(ev_raw),
		.sync_out(ev_level)
	);

	// detect rising edges on the synchronised levels
	sirq_edge #(
		.W(sirq_pkg::EV_W)
	) u_edge (
		.clk(clk),
		.reset(reset),
		.level(ev_level),
		.rise(ev_rise)
	);

	// ************************************************************
	// map events onto register bits
	// ************************************************************
	logic [sirq_pkg::REG_CNT-1:0][15:0] ev_set; // set requests per register

	// core request bits
	// request n drives bit n-1, request sixteen bit 15
	assign ev_set[0] = ev_rise[sirq_pkg::CORE_LSB +: 16];
	// short detection bits
	// outputs one to three on 5:0, output four on 9:8, right above left
	assign ev_set[1] = {6'h00, ev_rise[sirq_pkg::SHORT_LSB + sirq_pkg::SHORT_LOW_N +: 2], 2'h0,
		ev_rise[sirq_pkg::SHORT_LSB +: sirq_pkg::SHORT_LOW_N]};
	// enable-done bits
	// bits 5:4 are fed by the shared output three and four indication
	assign ev_set[2] = {10'h000, ev_rise[sirq_pkg::ON_LSB +: sirq_pkg::DONE_N]};
	// disable-done bits
	// same layout as the enable-done register
	assign ev_set[3] = {10'h000, ev_rise[sirq_pkg::OFF_LSB +: sirq_pkg::DONE_N]};
	// saturation bit
	// only bit 12 of this register is defined
	assign ev_set[4] = {3'h0, ev_rise[sirq_pkg::CLIP_BIT], 12'h000};

	// ************************************************************
	// flag, mask and read-data state
	// ************************************************************
	logic [sirq_pkg::REG_CNT-1:0][15:0] flag_q; // sticky flags
	logic [sirq_pkg::REG_CNT-1:0][15:0] flag_d; // next flags
	logic [sirq_pkg::REG_CNT-1:0][15:0] mask_q; // one masks a flag
	logic [sirq_pkg::REG_CNT-1:0][15:0] mask_d; // next masks
	logic [sirq_pkg::REG_CNT-1:0][15:0] clr_bits; // write-one clear bits
	logic [DATA_W-1:0] rdata_q; // read data, valid the cycle after a read
	logic [DATA_W-1:0] rdata_d; // next read data

	// decode writes, update flags and masks, pick the read data
	always_comb begin
		rdata_d = '0;
		for (int r = 0; r < sirq_pkg::REG_CNT; r++) begin
			// write one clears
			// a zero in the write data leaves the flag as it is
			if (reg_wr && (reg_addr == sirq_pkg::FLAG_OFS[r])) begin
				clr_bits[r] = reg_wdata[15:0];
			end else begin
				clr_bits[r] = 16'h0000;
			end
			// undefined bits stay zero
			// a new edge wins over a clear in the same cycle
			flag_d[r] = ((flag_q[r] & ~clr_bits[r]) | ev_set[r]) & sirq_pkg::VALID_BITS[r];
			// masks take plain writes at their own offsets
			if (reg_wr && (reg_addr == sirq_pkg::MASK_OFS_BASE + 16'(r))) begin
				mask_d[r] = reg_wdata[15:0] & sirq_pkg::VALID_BITS[r];
			end else begin
				mask_d[r] = mask_q[r];
			end
			// reads return the value before this cycle's update
			if (reg_rd && (reg_addr == sirq_pkg::FLAG_OFS[r])) begin
				rdata_d = flag_q[r];
			end else if (reg_rd && (reg_addr == sirq_pkg::MASK_OFS_BASE + 16'(r))) begin
				rdata_d = mask_q[r];
			end
		end
	end

	// register flags, masks and read data
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int r = 0; r < sirq_pkg::REG_CNT; r++) begin
				flag_q[r] <= sirq_pkg::FLAG_RESET;
				mask_q[r] <= sirq_pkg::MASK_RESET[r];
			end
			rdata_q <= '0;
		end else begin
			flag_q <= flag_d;
			mask_q <= mask_d;
			rdata_q <= rdata_d;
		end
	end

	// read data stand one cycle, zero otherwise
	assign reg_rdata = rdata_q;

	// ************************************************************
	// interrupt output
	// ************************************************************
	logic [sirq_pkg::REG_CNT-1:0] reg_pending; // unmasked flag per register

	// one pending term per register
	generate
		for (genvar g = 0; g < sirq_pkg::REG_CNT; g++) begin : g_pend
			assign reg_pending[g] = |(flag_q[g] & ~mask_q[g]);
		end
	endgenerate

	// level output, high while any unmasked flag is set
	assign irq = |reg_pending;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// helper: write-one clear bits of the core and short registers
	logic [15:0] clr_core; // clear bits aimed at the core flags
	logic [15:0] clr_short; // clear bits aimed at the short flags
	assign clr_core = clr_bits[0];
	assign clr_short = clr_bits[1];

	// a core request rise shows in its flag next cycle
	property p_core_set;
		(ev_set[0] != 16'h0000) |=> ((flag_q[0] & $past(ev_set[0])) == $past(ev_set[0]));
	endproperty
	a_core_set: assert property (p_core_set) else $error("core flag not set");

	// output four short on the right lands on bit 9
	property p_short4r_set;
		ev_rise[sirq_pkg::SHORT_LSB + 7] |=> flag_q[1][9];
	endproperty
	a_short4r_set: assert property (p_short4r_set) else $error("bit 9 not set");

	// output one short on the left lands on bit 0
	property p_short1l_set;
		ev_rise[sirq_pkg::SHORT_LSB] |=> flag_q[1][0];
	endproperty
	a_short1l_set: assert property (p_short1l_set) else $error("bit 0 not set");

	// shared enable-done right lands on bit 5
	property p_on_set;
		ev_rise[sirq_pkg::ON_LSB + 5] |=> flag_q[2][5];
	endproperty
	a_on_set: assert property (p_on_set) else $error("enable flag 5 not set");

	// disable-done left of output one lands on bit 0
	property p_off_set;
		ev_rise[sirq_pkg::OFF_LSB] |=> flag_q[3][0];
	endproperty
	a_off_set: assert property (p_off_set) else $error("disable flag 0 not set");

	// saturation reaches bit 12 two sync stages plus one after the source
	sequence s_clip_rise;
		!ev_level[sirq_pkg::CLIP_BIT] ##1 ev_level[sirq_pkg::CLIP_BIT];
	endsequence
	property p_clip_set;
		s_clip_rise |=> flag_q[4][sirq_pkg::CLIP_POS];
	endproperty
	a_clip_set: assert property (p_clip_set) else $error("saturation flag not set");

	// a set flag with no clear written stays set
	property p_core_hold;
		(flag_q[0][3] && !clr_core[3]) |=> flag_q[0][3];
	endproperty
	a_core_hold: assert property (p_core_hold) else $error("flag dropped");

	// writing one with no new edge clears the flag
	property p_short_clear;
		(clr_short[2] && !ev_set[1][2]) |=> !flag_q[1][2];
	endproperty
	a_short_clear: assert property (p_short_clear) else $error("flag not cleared");

	// undefined positions of the short flags and short mask never hold a one
	property p_reserved_zero;
		((flag_q[1] | mask_q[1]) & ~sirq_pkg::VALID_BITS[1]) == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	// a source held high after its clear does not set the flag again
	sequence s_clear_held;
		clr_core[0] && ev_level[sirq_pkg::CORE_LSB] && !ev_set[0][0];
	endsequence
	property p_no_reset_held;
		s_clear_held ##1 ev_level[sirq_pkg::CORE_LSB] [*2] |=> !flag_q[0][0];
	endproperty
	a_no_reset_held: assert property (p_no_reset_held) else $error("flag re-set");

	// a read returns the flags seen in the read cycle, one cycle later
	property p_read_core;
		(reg_rd && reg_addr == sirq_pkg::CORE_REQUEST_EVENT_FLAGS)
			|=> (reg_rdata == $past(flag_q[0]));
	endproperty
	a_read_core: assert property (p_read_core) else $error("bad read data");

	// an unmasked saturation flag raises the interrupt
	property p_irq_clip;
		(flag_q[4][sirq_pkg::CLIP_POS] && !mask_q[4][sirq_pkg::CLIP_POS]) |-> irq;
	endproperty
	a_irq_clip: assert property (p_irq_clip) else $error("irq missing");

	// output four short on the left lands on bit 8
	property p_short4l_set;
		ev_rise[sirq_pkg::SHORT_LSB + 6] |=> flag_q[1][8];
	endproperty
	a_short4l_set: assert property (p_short4l_set) else $error("bit 8 not set");

	// output three short on the right lands on bit 5
	property p_short3r_set;
		ev_rise[sirq_pkg::SHORT_LSB + 5] |=> flag_q[1][5];
	endproperty
	a_short3r_set: assert property (p_short3r_set) else $error("bit 5 not set");

	// shared enable-done left lands on bit 4
	property p_on_left_set;
		ev_rise[sirq_pkg::ON_LSB + 4] |=> flag_q[2][4];
	endproperty
	a_on_left_set: assert property (p_on_left_set) else $error("enable flag 4 not set");

	// shared disable-done right lands on bit 5
	property p_off_right_set;
		ev_rise[sirq_pkg::OFF_LSB + 5] |=> flag_q[3][5];
	endproperty
	a_off_right_set: assert property (p_off_right_set) else $error("disable flag 5 not set");

	// request sixteen reaches bit 15 one cycle after its level rises
	sequence s_core16_rise;
		!ev_level[sirq_pkg::CORE_LSB + 15] ##1 ev_level[sirq_pkg::CORE_LSB + 15];
	endsequence
	property p_core16_set;
		s_core16_rise |=> flag_q[0][15];
	endproperty
	a_core16_set: assert property (p_core16_set) else $error("core flag 15 not set");

	// a set saturation flag with no clear written stays set
	property p_clip_hold;
		(flag_q[4][sirq_pkg::CLIP_POS] && !clr_bits[4][sirq_pkg::CLIP_POS])
			|=> flag_q[4][sirq_pkg::CLIP_POS];
	endproperty
	a_clip_hold: assert property (p_clip_hold) else $error("saturation flag dropped");

	// a zero write keeps every enable-done flag that was set
	property p_zero_write_keeps;
		(reg_wr && reg_addr == sirq_pkg::OUTPUT_ENABLE_DONE_FLAGS && reg_wdata == 16'h0000)
			|=> ((flag_q[2] & $past(flag_q[2])) == $past(flag_q[2]));
	endproperty
	a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write cleared");

	// a read of the saturation register shows zero in undefined bits
	property p_read_conv_reserved;
		(reg_rd && reg_addr == sirq_pkg::CONVERTER_SATURATE_FLAGS)
			|=> ((reg_rdata & ~sirq_pkg::VALID_BITS[4]) == 16'h0000);
	endproperty
	a_read_conv_reserved: assert property (p_read_conv_reserved) else $error("reserved read one");

	// read data fall back to zero when no read was made
	property p_rdata_idle;
		!reg_rd |=> (reg_rdata == 16'h0000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

	// a mask read returns the mask seen in the read cycle
	property p_read_mask;
		(reg_rd && reg_addr == sirq_pkg::MASK_OFS_BASE)
			|=> (reg_rdata == $past(mask_q[0]));
	endproperty
	a_read_mask: assert property (p_read_mask) else $error("bad mask read data");

	// no flag set means no interrupt
	property p_irq_quiet;
		(flag_q == '0) |-> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq without flag");

endmodule : sirq_bank

// File: sirq_pkg.sv
// sirq_pkg: register map, field positions and reset values of the
// secondary interrupt status bank.
// assumes: a plain register port with 16-bit data and 16-bit addresses.

package sirq_pkg;

	// ************************************************************
	// bus geometry
	// ************************************************************
	localparam int ADDR_W = 16; // register address width
	localparam int DATA_W = 16; // register data width
	localparam int REG_CNT = 5; // number of flag registers

	// ************************************************************
	// flag register offsets
	// ************************************************************
	localparam logic [15:0] CORE_REQUEST_EVENT_FLAGS = 16'h190A;
	localparam logic [15:0] OUTPUT_SHORT_EVENT_FLAGS = 16'h190B;
	localparam logic [15:0] OUTPUT_ENABLE_DONE_FLAGS = 16'h190C;
	localparam logic [15:0] OUTPUT_DISABLE_DONE_FLAGS = 16'h190D;
	localparam logic [15:0] CONVERTER_SATURATE_FLAGS = 16'h190E;
	// mask registers, one per flag register, same layout
	localparam logic [15:0] MASK_OFS_BASE = 16'h1A0A;

	// flag offsets indexed by register number
	localparam logic [REG_CNT-1:0][15:0] FLAG_OFS = {
		CONVERTER_SATURATE_FLAGS, OUTPUT_DISABLE_DONE_FLAGS,
		OUTPUT_ENABLE_DONE_FLAGS, OUTPUT_SHORT_EVENT_FLAGS,
		CORE_REQUEST_EVENT_FLAGS};

	// defined bits of each register; the rest read zero
	localparam logic [REG_CNT-1:0][15:0] VALID_BITS = {
		16'h1000, 16'h003F, 16'h003F, 16'h033F, 16'hFFFF};

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [15:0] FLAG_RESET = 16'h0000; // flags clear
	// all events masked after reset
	localparam logic [REG_CNT-1:0][15:0] MASK_RESET = VALID_BITS;

	// ************************************************************
	// positions in the raw event vector
	// ************************************************************
	localparam int CORE_LSB = 0; // 16 core requests, request n at n-1
	localparam int SHORT_LSB = 16; // 8 short detections
	localparam int ON_LSB = 24; // 6 enable-done indications
	localparam int OFF_LSB = 30; // 6 disable-done indications
	localparam int CLIP_BIT = 36; // converter saturation
	localparam int EV_W = 37; // raw event vector width

	// ************************************************************
	// positions inside the registers
	// ************************************************************
	localparam int SHORT_LOW_N = 6; // outputs one to three, bits 5:0
	localparam int SHORT_HI_LSB = 8; // output four, bits 9:8
	localparam int DONE_N = 6; // done flags, bits 5:0
	localparam int CLIP_POS = 12; // saturation flag bit

endpackage : sirq_pkg

// File: sirq_sync.sv
// sirq_sync: two-stage level synchroniser, one stage pair per bit.
// assumes: inputs come from another domain; only the second stage is read.

`timescale 1ns/1ns

module sirq_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	// ************************************************************
	// synchroniser stages
	// ************************************************************
	logic [W-1:0] meta_q; // first stage, read only by second stage
	logic [W-1:0] sync_q; // second stage, safe to use

	// shift the level through two flops
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : sirq_sync

// File: sirq_edge.sv
// sirq_edge: rising-edge detector for a vector of synchronised levels.
// assumes: levels are already in the clk domain.

`timescale 1ns/1ns

module sirq_edge #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise
);

	// ************************************************************
	// previous level
	// ************************************************************
	logic [W-1:0] prev_q; // level seen last cycle
	logic [W-1:0] prev_d; // next previous level

	// next value is simply the current level
	always_comb begin
		prev_d = level;
	end

	// register the level
	always_ff @(posedge clk) begin
		if (reset) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end

	// a one-cycle pulse where the level goes from low to high
	assign rise = level & ~prev_q;

endmodule : sirq_edge

// File: tb.sv
// tb: self-checking bench for the secondary interrupt status bank.
// assumes: sirq_pkg and sirq_bank are compiled first; one 50 MHz clock.

`timescale 1ns/1ns

module tb;

	// ************************************************************
	// stimulus and bookkeeping
	// ************************************************************
	logic clk = 1'b0; // 50 MHz clock
	logic reset = 1'b1; // synchronous reset, active high
	logic [15:0] reg_addr = 16'h0000; // register address
	logic [15:0] reg_wdata = 16'h0000; // write data
	logic reg_wr = 1'b0; // write strobe
	logic reg_rd = 1'b0; // read strobe
	logic [15:0] reg_rdata; // read data, one cycle after the strobe
	logic [15:0] core_req = 16'h0000; // core request levels
	logic [7:0] out_short = 8'h00; // short detect levels
	logic [5:0] out_on_done = 6'h00; // enable-done levels
	logic [5:0] out_off_done = 6'h00; // disable-done levels
	logic converter_clip = 1'b0; // converter saturation level
	logic irq; // level interrupt output
	int n_errors = 0; // mismatches seen
	int checked = 0; // comparisons made

	// free-running clock, 20 ns period
	always #10 clk = ~clk;

	sirq_bank DUT (
		.clk(clk),
		.reset(reset),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.core_req(core_req),
		.out_short(out_short),
		.out_on_done(out_on_done),
		.out_off_done(out_off_done),
		.converter_clip(converter_clip),
		.irq(irq)
	);

	// ************************************************************
	// shared tasks
	// ************************************************************
	// compare one value and count it
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : chk

	// one-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// one-cycle read strobe; data taken in the following cycle
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// drive one event source level
	task automatic set_src(input int grp, input int b, input logic v);
		@(posedge clk);
		case (grp)
			0: core_req[b] <= v;
			1: out_short[b] <= v;
			2: out_on_done[b] <= v;
			3: out_off_done[b] <= v;
			default: converter_clip <= v;
		endcase
	endtask : set_src

	// raise a source, check the whole bank, clear with one and hold the source
	task automatic ev_case(input int grp, input int b, input logic [15:0] ofs,
		input logic [15:0] exp);
		logic [15:0] d;
		logic [15:0] a;
		set_src(grp, b, 1'b1);
		repeat (6) @(posedge clk);
		for (int r = 0; r < sirq_pkg::REG_CNT; r++) begin
			a = sirq_pkg::FLAG_OFS[r];
			rd(a, d);
			chk("flag bank", (a == ofs) ? exp : 16'h0000, d);
		end
		wr(ofs, 16'h0000);
		rd(ofs, d);
		chk("flag after zero write", exp, d);
		wr(ofs, exp);
		repeat (4) @(posedge clk);
		rd(ofs, d);
		chk("flag cleared, source held", 16'h0000, d);
		set_src(grp, b, 1'b0);
		repeat (4) @(posedge clk);
	endtask : ev_case

	// ************************************************************
	// scenarios
	// ************************************************************
	// reset values, mask defaults and read data standing one cycle
	task automatic t_reset;
		logic [15:0] d;
		for (int r = 0; r < sirq_pkg::REG_CNT; r++) begin
			rd(sirq_pkg::FLAG_OFS[r], d);
			chk("flag reset", sirq_pkg::FLAG_RESET, d);
			rd(sirq_pkg::MASK_OFS_BASE + 16'(r), d);
			chk("mask reset", sirq_pkg::VALID_BITS[r], d);
			@(posedge clk);
			#1 chk("read data after its cycle", 16'h0000, reg_rdata);
		end
		chk("irq after reset", 16'h0000, {15'h0000, irq});
	endtask : t_reset

	// every source of every register, one at a time
	task automatic t_events;
		for (int b = 0; b < 16; b++) begin
			ev_case(0, b, sirq_pkg::CORE_REQUEST_EVENT_FLAGS, 16'h0001 << b);
		end
		for (int b = 0; b < 8; b++) begin
			ev_case(1, b, sirq_pkg::OUTPUT_SHORT_EVENT_FLAGS,
				(b < 6) ? (16'h0001 << b) : (16'h0001 << (b + 2)));
		end
		for (int b = 0; b < 6; b++) begin
			ev_case(2, b, sirq_pkg::OUTPUT_ENABLE_DONE_FLAGS, 16'h0001 << b);
			ev_case(3, b, sirq_pkg::OUTPUT_DISABLE_DONE_FLAGS, 16'h0001 << b);
		end
		ev_case(4, 0, sirq_pkg::CONVERTER_SATURATE_FLAGS, 16'h1000);
	endtask : t_events

	// a fresh rising edge after a clear sets the flag again
	task automatic t_rearm;
		logic [15:0] d;
		set_src(0, 15, 1'b1);
		repeat (6) @(posedge clk);
		wr(sirq_pkg::CORE_REQUEST_EVENT_FLAGS, 16'h8000);
		set_src(0, 15, 1'b0);
		repeat (4) @(posedge clk);
		set_src(0, 15, 1'b1);
		repeat (6) @(posedge clk);
		rd(sirq_pkg::CORE_REQUEST_EVENT_FLAGS, d);
		chk("flag on new edge", 16'h8000, d);
		wr(sirq_pkg::CORE_REQUEST_EVENT_FLAGS, 16'h8000);
		set_src(0, 15, 1'b0);
		repeat (4) @(posedge clk);
	endtask : t_rearm

	// interrupt raised when unmasked, hidden by the mask, dropped by the clear
	task automatic t_irq;
		logic [15:0] d;
		logic [15:0] m;
		m = sirq_pkg::MASK_OFS_BASE + 16'h0001;
		wr(m, 16'h0000);
		set_src(1, 7, 1'b1);
		repeat (6) @(posedge clk);
		#1 chk("irq unmasked", 16'h0001, {15'h0000, irq});
		wr(m, 16'h0200);
		#1 chk("irq masked", 16'h0000, {15'h0000, irq});
		wr(m, 16'h0000);
		#1 chk("irq unmasked again", 16'h0001, {15'h0000, irq});
		wr(sirq_pkg::OUTPUT_SHORT_EVENT_FLAGS, 16'h0200);
		#1 chk("irq after clear", 16'h0000, {15'h0000, irq});
		set_src(1, 7, 1'b0);
		wr(m, 16'hFFFF);
		rd(m, d);
		chk("mask undefined bits", 16'h033F, d);
	endtask : t_irq

	// unmapped address and undefined bits
	task automatic t_unmapped;
		logic [15:0] d;
		wr(16'h1909, 16'hFFFF);
		rd(16'h1909, d);
		chk("unmapped read", 16'h0000, d);
		set_src(4, 0, 1'b1);
		repeat (6) @(posedge clk);
		wr(sirq_pkg::CONVERTER_SATURATE_FLAGS, 16'hEFFF);
		rd(sirq_pkg::CONVERTER_SATURATE_FLAGS, d);
		chk("undefined bits", 16'h1000, d);
		wr(sirq_pkg::CONVERTER_SATURATE_FLAGS, 16'hFFFF);
		rd(sirq_pkg::CONVERTER_SATURATE_FLAGS, d);
		chk("undefined bits after clear", 16'h0000, d);
		set_src(4, 0, 1'b0);
		repeat (4) @(posedge clk);
	endtask : t_unmapped

	// a reset in mid-run drops the flags and masks everything again
	task automatic t_midreset;
		logic [15:0] d;
		wr(sirq_pkg::MASK_OFS_BASE, 16'h0000);
		set_src(0, 2, 1'b1);
		repeat (6) @(posedge clk);
		#1 chk("irq before reset", 16'h0001, {15'h0000, irq});
		set_src(0, 2, 1'b0);
		repeat (4) @(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1 chk("irq after mid reset", 16'h0000, {15'h0000, irq});
		rd(sirq_pkg::CORE_REQUEST_EVENT_FLAGS, d);
		chk("flag after mid reset", sirq_pkg::FLAG_RESET, d);
		rd(sirq_pkg::MASK_OFS_BASE, d);
		chk("mask after mid reset", sirq_pkg::VALID_BITS[0], d);
	endtask : t_midreset

	// ************************************************************
	// closing, main sequence and watchdog
	// ************************************************************
	// print counts and verdict, then stop
	task automatic end_sim;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	// reset for five cycles, then every scenario in turn
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_events();
		t_rearm();
		t_irq();
		t_unmapped();
		t_midreset();
		end_sim();
	end

	// cuts a hang short well past the expected run of about 1400 cycles
	initial begin
		#200000;
		n_errors++;
		$display("watchdog expired");
		end_sim();
	end

endmodule : tb
